/* logic/mss_map.vh */
`ifndef MSS_MAP_VH
`define MSS_MAP_VH
`define MSS_CLK_NS 10
`define MSS_CYC_UP(t) (((t) + `MSS_CLK_NS - 1) / `MSS_CLK_NS)
`define MSS_T_INIT_NS 60000
`define MSS_T_DET_NS 30000
`define MSS_T_HOLD_NS 50000
`define MSS_T_MINON_NS 130
`define MSS_MINON_DIV 12
`define MSS_CLK_HI_PCT 40
`define MSS_ADDR_CONFIG 8'h00
`define MSS_ADDR_STATUS 8'h04
`define MSS_CFG_PERIOD_LSB 0
`define MSS_CFG_DUTY_LSB 16
`define MSS_RST_PERIOD 10'h064
`define MSS_RST_DUTY 10'h032
`define MSS_ST_STATE_LSB 0
`define MSS_ST_ACTN_LSB 8
`define MSS_ST_CFGN_LSB 12
`define MSS_ST_LATCH_BIT 16
`define MSS_ST_DE_BIT 17
`define MSS_ST_SKIP_BIT 18
`define MSS_ST_DRVEN_BIT 19
`define MSS_ST_OUTPUT_OK_FLAG_BIT 20
`endif

/* logic/mss_top.v */
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "mss_map.vh"
// Function
// - tri select low: outputs low/high only
// - tri select high: mid level turns driver off
// - fixed-phase tri: min on-time period/12
// - shutdown until enable, then await power-on
// - initialisation and calibration interval after power-on
// - thirty microsecond phase detection sampling pins
// - phase one or two high: latch off
// - pin four high three phases; three two
// - wait pll lock, then clock output toggles
// - safe hold fifty microseconds, drivers disabled
// - pre-bias soft-start node during hold
// - soft-start ends at ramp threshold
// - driver enable rises at first phase toggle
// - tri soft-start: mid and low only
// - tri after soft-start: full two-level switching
// - two-level soft-start: low/high from start
// - drop phases with load, minimum two
// - order: drop, diode emulation, pulse skip
// - diode emulation: sync off at zero current, tri select only, phases one and two
// - power good once output in window
module mss_top #(
   parameter PW = 10,
   parameter [15:0] INIT_CYC = `MSS_CYC_UP(`MSS_T_INIT_NS),
   parameter [15:0] HOLD_CYC = `MSS_CYC_UP(`MSS_T_HOLD_NS)
) (
   input wire ref_clk,
   input wire srst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire enable_ok,
   input wire por_done,
   input wire mode_fixed,
   input wire tri_level_sel,
   input wire [3:0] phase_in,
   input wire pll_locked,
   input wire ss_done,
   input wire output_in_window,
   input wire load_lt_3ph,
   input wire load_lt_2ph,
   input wire light_load,
   input wire deep_light_load,
   input wire [1:0] inductor_zero,
   output reg [3:0] phase_out,
   output reg [3:0] phase_mid,
   output reg [3:0] phase_oe_n,
   output reg drive_enable,
   output reg clk_out,
   output reg prebias_en,
   output reg output_ok_flag,
   output reg latched_off
);
   // one-hot sequencer states; an illegal code falls back to shutdown
   localparam [7:0] S_SHUT = 8'h01;
   localparam [7:0] S_INIT = 8'h02;
   localparam [7:0] S_DET = 8'h04;
   localparam [7:0] S_PLLW = 8'h08;
   localparam [7:0] S_HOLD = 8'h10;
   localparam [7:0] S_SOFT = 8'h20;
   localparam [7:0] S_RUN = 8'h40;
   localparam [7:0] S_LATCH = 8'h80;
   localparam [15:0] DET_CYC = `MSS_CYC_UP(`MSS_T_DET_NS);
   localparam [PW-1:0] MINON_CYC = `MSS_CYC_UP(`MSS_T_MINON_NS);

   reg [7:0] state;
   reg [15:0] tmr;
   reg [3:0] seen;
   reg [2:0] cfg_n;
   reg [2:0] act_n;
   reg [PW-1:0] period;
   reg [PW-1:0] duty;
   reg [PW-1:0] duty_cur;
   reg [PW-1:0] cnt;
   reg started;
   reg diode_emul;
   reg pulse_skip;
   reg ap_valid;
   reg ap_wr;
   reg [7:0] ap_addr;

   wire st_shut = (state == S_SHUT);
   wire st_init = (state == S_INIT);
   wire st_det = (state == S_DET);
   wire st_hold = (state == S_HOLD);
   wire st_soft = (state == S_SOFT);
   wire st_run = (state == S_RUN);
   wire drop_en = ~mode_fixed;
   // a period below about sixteen cycles gives meaningless phasing; there is no clamp
   wire cnt_wrap = (cnt >= period - 1'b1);
   // fixed phases with tri select: sync duty capped through the low-side minimum
   wire case_a = mode_fixed & tri_level_sel;
   wire [31:0] per_div12 = period / `MSS_MINON_DIV;
   wire [31:0] per_div3 = period / 3;
   // floor division keeps the cap on the safe side
   wire [PW-1:0] minon = case_a ? per_div12[PW-1:0] : MINON_CYC;
   // skipped pulses bypass the forced minimum so deep light load really stops switching
   wire [PW-1:0] duty_req = pulse_skip ? {PW{1'b0}} : duty_cur;
   wire [PW-1:0] eff_duty = (duty_req == {PW{1'b0}}) ? duty_req : ((duty_req < minon) ? minon : duty_req);
   wire [PW-1:0] step = (act_n == 3'd4) ? (period >> 2) : ((act_n == 3'd3) ? per_div3[PW-1:0] : (period >> 1));
   // clock output high for the first forty percent of each period
   wire [PW+6:0] clk_prod = {7'b0, period} * 7'd`MSS_CLK_HI_PCT;
   wire [PW+6:0] clk_thr = clk_prod / 7'd100;
   // only phases one and two sense zero current
   wire [3:0] izero4 = {2'b00, inductor_zero};
   wire [3:0] on_v;
   wire [3:0] next_out;
   wire [3:0] next_mid;
   wire [3:0] next_oe_n;
   wire next_started = started | (st_soft & on_v[0]);
   wire next_drive_enable = next_started & (st_soft | st_run);
   wire next_clk_out = (st_hold | st_soft | st_run) & ({7'b0, cnt} < clk_thr);
   wire next_ok = st_run & output_in_window;
   // pin three wins if both are tied high
   wire [2:0] det_n = (seen[2] | phase_in[2]) ? 3'd2 :
                      ((seen[3] | phase_in[3]) ? 3'd3 : 3'd4);

   // each phase compares the shared counter, shifted by k steps, against the duty
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_ph
         localparam [PW+1:0] KW = k;
         localparam [2:0] K3 = k;
         wire [PW+1:0] offw = {2'b00, step} * KW;
         wire [PW:0] sum = {1'b0, cnt} + {1'b0, offw[PW-1:0]};
         wire [PW:0] sub = sum - {1'b0, period};
         wire [PW-1:0] pos = (sum >= {1'b0, period}) ? sub[PW-1:0] : sum[PW-1:0];
         wire on = (pos < eff_duty);
         wire act = (K3 < act_n);
         wire sw = act & ((st_soft & next_started) | st_run);
         wire drop = st_run & ~act;
         // with tri select, diode emulation leaves the phase at mid level once its current is near zero
         wire dez = diode_emul & izero4[k];
         // soft-start with tri select never lets the sync switch on
         wire mid_sw = ~on & tri_level_sel & (st_soft | dez);
         assign on_v[k] = on;
         // low level turns the low-side switch on; high is the sync switch
         assign next_out[k] = sw ? (~on & ~mid_sw) : (drop & ~tri_level_sel);
         assign next_mid[k] = sw ? mid_sw : (drop & tri_level_sel);
         // safe state: high impedance until detection ends or with tri select, else driven low
         assign next_oe_n[k] = (sw | drop) ? 1'b0 : (st_shut | st_init | st_det | tri_level_sel);
      end
   endgenerate

   reg [2:0] next_act_n;
   reg next_diode_emul;
   reg next_pulse_skip;
   // fixed mode, or any state but run, keeps every detected phase
   always @* begin
      next_act_n = cfg_n;
      next_diode_emul = 1'b0;
      next_pulse_skip = 1'b0;
      if (st_run && drop_en) begin
         // never below two phases, never above the detected count
         if (load_lt_2ph || cfg_n == 3'd2) begin
            next_act_n = 3'd2;
         end else if (load_lt_3ph || cfg_n == 3'd3) begin
            next_act_n = 3'd3;
         end else begin
            next_act_n = 3'd4;
         end
         // each lighter method only once the previous one is in force
         next_diode_emul = (act_n == 3'd2) & light_load;
         next_pulse_skip = diode_emul & light_load & deep_light_load;
      end
   end

   reg [PW-1:0] next_duty_cur;
   always @* begin
      next_duty_cur = {PW{1'b0}};
      if (st_soft) begin
         // one step per switching period so duty rises from zero
         next_duty_cur = duty_cur;
         if (cnt_wrap && duty_cur < duty) begin
            next_duty_cur = duty_cur + 1'b1;
         end
      end else if (st_run) begin
         next_duty_cur = duty;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         state <= S_SHUT;
         tmr <= 16'h0000;
         seen <= 4'h0;
         cfg_n <= 3'd4;
         latched_off <= 1'b0;
      end else begin
         case (state)
            S_SHUT: begin
               if (enable_ok && por_done) begin
                  state <= S_INIT;
                  tmr <= INIT_CYC - 16'h0001;
               end
            end
            S_INIT: begin
               if (tmr == 16'h0000) begin
                  state <= S_DET;
                  tmr <= DET_CYC - 16'h0001;
                  seen <= 4'h0;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            S_DET: begin
               seen <= seen | phase_in;
               if (phase_in[0] || phase_in[1]) begin
                  state <= S_LATCH;
                  latched_off <= 1'b1;
               end else if (tmr == 16'h0000) begin
                  state <= S_PLLW;
                  cfg_n <= det_n;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            S_PLLW: begin
               if (pll_locked) begin
                  state <= S_HOLD;
                  tmr <= HOLD_CYC - 16'h0001;
               end
            end
            S_HOLD: begin
               if (tmr == 16'h0000) begin
                  state <= S_SOFT;
               end else begin
                  tmr <= tmr - 16'h0001;
               end
            end
            S_SOFT: begin
               // the ramp must have moved phase one before run may begin
               if (ss_done && started) begin
                  state <= S_RUN;
               end
            end
            S_RUN: begin
               // run and latch are final until the next reset
               state <= S_RUN;
            end
            S_LATCH: begin
               state <= S_LATCH;
            end
            default: begin
               state <= S_SHUT;
            end
         endcase
      end
   end

   // oscillator runs free; clock output and phases follow it
   always @(posedge ref_clk) begin
      if (srst) begin
         cnt <= {PW{1'b0}};
         duty_cur <= {PW{1'b0}};
         started <= 1'b0;
         act_n <= 3'd4;
         diode_emul <= 1'b0;
         pulse_skip <= 1'b0;
      end else begin
         cnt <= cnt_wrap ? {PW{1'b0}} : cnt + 1'b1;
         started <= next_started & (st_soft | st_run);
         duty_cur <= next_duty_cur;
         act_n <= next_act_n;
         diode_emul <= next_diode_emul;
         pulse_skip <= next_pulse_skip;
      end
   end

   // every pin output is registered so the pads never see decode glitches
   always @(posedge ref_clk) begin
      if (srst) begin
         phase_out <= 4'h0;
         phase_mid <= 4'h0;
         phase_oe_n <= 4'hF;
         drive_enable <= 1'b0;
         clk_out <= 1'b0;
         prebias_en <= 1'b0;
         output_ok_flag <= 1'b0;
      end else begin
         phase_out <= next_out;
         phase_mid <= next_mid;
         phase_oe_n <= next_oe_n;
         drive_enable <= next_drive_enable;
         clk_out <= next_clk_out;
         prebias_en <= st_hold;
         output_ok_flag <= next_ok;
      end
   end

   // zero-wait slave: read data is captured in the address phase
   // hreadyout never drops, so every address phase is taken at once
   wire ap_take = hsel & hready & htrans[1];
   wire cfg_wr = ap_valid & ap_wr & (ap_addr == `MSS_ADDR_CONFIG);
   wire [PW-1:0] wr_period = hwdata[`MSS_CFG_PERIOD_LSB+PW-1:`MSS_CFG_PERIOD_LSB];
   wire [PW-1:0] wr_duty = hwdata[`MSS_CFG_DUTY_LSB+PW-1:`MSS_CFG_DUTY_LSB];
   // a read in the cycle after a write sees the new value through the bypass
   wire [31:0] cfg_word = cfg_wr ? hwdata :
                          ({16'h0000, {(16-PW){1'b0}}, period} | ({{(16-PW){1'b0}}, duty, 16'h0000}));
   wire [31:0] st_f_state = {24'h000000, state} << `MSS_ST_STATE_LSB;
   wire [31:0] st_f_act = {29'h0, act_n} << `MSS_ST_ACTN_LSB;
   wire [31:0] st_f_cfg = {29'h0, cfg_n} << `MSS_ST_CFGN_LSB;
   wire [31:0] st_f_latch = {31'h0, latched_off} << `MSS_ST_LATCH_BIT;
   wire [31:0] st_f_de = {31'h0, diode_emul} << `MSS_ST_DE_BIT;
   wire [31:0] st_f_skip = {31'h0, pulse_skip} << `MSS_ST_SKIP_BIT;
   wire [31:0] st_f_drv = {31'h0, drive_enable} << `MSS_ST_DRVEN_BIT;
   wire [31:0] st_f_ok = {31'h0, output_ok_flag} << `MSS_ST_OUTPUT_OK_FLAG_BIT;
   wire [31:0] stat_word = st_f_state | st_f_act | st_f_cfg | st_f_latch |
                           st_f_de | st_f_skip | st_f_drv | st_f_ok;
   wire [31:0] cfg_rd = cfg_wr ?
                        (({16'h0000, {(16-PW){1'b0}}, hwdata[`MSS_CFG_PERIOD_LSB+PW-1:`MSS_CFG_PERIOD_LSB]}) |
                         ({{(16-PW){1'b0}}, hwdata[`MSS_CFG_DUTY_LSB+PW-1:`MSS_CFG_DUTY_LSB], 16'h0000})) :
                        cfg_word;
   wire addr_hi_ok = (haddr[31:8] == 24'h000000);
   reg [31:0] next_hrdata;
   always @* begin
      next_hrdata = hrdata;
      if (ap_take && !hwrite) begin
         next_hrdata = 32'h00000000;
         if (addr_hi_ok) begin
            case (haddr[7:0])
               `MSS_ADDR_CONFIG: begin
                  next_hrdata = cfg_rd;
               end
               `MSS_ADDR_STATUS: begin
                  next_hrdata = stat_word;
               end
               default: begin
                  next_hrdata = 32'h00000000;
               end
            endcase
         end
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         ap_valid <= 1'b0;
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         period <= `MSS_RST_PERIOD;
         duty <= `MSS_RST_DUTY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready) begin
            ap_valid <= ap_take;
            ap_wr <= hwrite;
            ap_addr <= haddr[7:0];
         end
         hrdata <= next_hrdata;
         // period and duty change only at a data phase, never mid-transfer
         if (cfg_wr) begin
            period <= wr_period;
            duty <= wr_duty;
         end
      end
   end
endmodule

/* verif/mss_checker.sv */
`timescale 1ns/1ns
module mss_checker (
   input wire ref_clk,
   input wire srst,
   input wire tri_level_sel,
   input wire pll_locked,
   input wire output_in_window,
   input wire [3:0] phase_out,
   input wire [3:0] phase_mid,
   input wire [3:0] phase_oe_n,
   input wire drive_enable,
   input wire prebias_en,
   input wire output_ok_flag,
   input wire latched_off
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (srst);
   AST_HOLD_SAFE: assert property (prebias_en |-> !drive_enable && phase_out == 4'h0)
      else $error("hold not safe");
   AST_HOLD_OE: assert property (prebias_en |-> phase_oe_n == {4{tri_level_sel}})
      else $error("hold pin state wrong");
   AST_TWO_LVL: assert property (!tri_level_sel |-> phase_mid == 4'h0)
      else $error("mid level in two-level mode");
   AST_MID_LOW: assert property ((phase_mid & phase_out) == 4'h0)
      else $error("mid level with high");
   AST_LATCH_STAY: assert property (latched_off |=> latched_off)
      else $error("latch released");
   AST_LATCH_OFF: assert property (latched_off |-> !drive_enable && !prebias_en)
      else $error("latched but active");
   AST_OUTPUT_OK_FLAG: assert property (output_ok_flag |-> $past(output_in_window))
      else $error("power good without window");
   AST_DRV_STAY: assert property (drive_enable |=> drive_enable)
      else $error("driver enable dropped");
   AST_CLK_LOCK: assert property ($rose(prebias_en) |-> pll_locked)
      else $error("hold before lock");
   AST_DRV_RISE: assert property ($rose(drive_enable) |-> ##[0:1] !phase_oe_n[0] && !phase_mid[0])
      else $error("enable without phase one toggle");
endmodule
bind mss_top mss_checker u_mss_checker (.ref_clk(ref_clk), .srst(srst), .tri_level_sel(tri_level_sel),
   .pll_locked(pll_locked), .output_in_window(output_in_window), .phase_out(phase_out),
   .phase_mid(phase_mid), .phase_oe_n(phase_oe_n), .drive_enable(drive_enable),
   .prebias_en(prebias_en), .output_ok_flag(output_ok_flag), .latched_off(latched_off));

/* verif/mss_driver_model.sv */
`timescale 1ns/1ns
module mss_driver_model (
   input wire [3:0] phase_out,
   input wire [3:0] phase_mid,
   input wire [3:0] phase_oe_n,
   input wire drive_enable,
   input wire [3:0] pin_tie,
   output wire [3:0] phase_in,
   output wire [3:0] gate_hi,
   output wire [3:0] gate_lo
);
   wire [3:0] live;
   // released pin settles to its board strap, pulled low when unstrapped
   assign phase_in = (phase_oe_n & pin_tie) | (~phase_oe_n & phase_out);
   // mid level or a disabled driver keeps both switches off
   assign live = {4{drive_enable}} & ~phase_oe_n & ~phase_mid;
   assign gate_hi = live & phase_out;
   assign gate_lo = live & ~phase_out;
endmodule

/* verif/mss_top_test.sv */
`timescale 1ns/1ns
module mss_top_test;
   reg ref_clk, srst, hsel, hwrite, enable_ok, por_done, mode_fixed, tri_level_sel, pll_locked, ss_done;
   reg output_in_window, load_lt_3ph, load_lt_2ph, light_load, deep_light_load;
   reg [1:0] htrans, inductor_zero;
   reg [3:0] pin_tie, acc;
   reg [31:0] haddr, hwdata, st;
   wire [31:0] hrdata;
   wire hreadyout, hresp, drive_enable, clk_out, prebias_en, output_ok_flag, latched_off;
   wire [3:0] phase_in, phase_out, phase_mid, phase_oe_n, gate_hi, gate_lo;
   integer fail_count, cmp_count;
   mss_top #(.INIT_CYC(16'h0014), .HOLD_CYC(16'h0014)) u_mss_top (.ref_clk(ref_clk), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enable_ok(enable_ok),
      .por_done(por_done), .mode_fixed(mode_fixed), .tri_level_sel(tri_level_sel), .phase_in(phase_in),
      .pll_locked(pll_locked), .ss_done(ss_done), .output_in_window(output_in_window),
      .load_lt_3ph(load_lt_3ph), .load_lt_2ph(load_lt_2ph), .light_load(light_load),
      .deep_light_load(deep_light_load), .inductor_zero(inductor_zero), .phase_out(phase_out),
      .phase_mid(phase_mid), .phase_oe_n(phase_oe_n), .drive_enable(drive_enable), .clk_out(clk_out),
      .prebias_en(prebias_en), .output_ok_flag(output_ok_flag), .latched_off(latched_off));
   mss_driver_model u_mss_driver_model (.phase_out(phase_out), .phase_mid(phase_mid),
      .phase_oe_n(phase_oe_n), .drive_enable(drive_enable), .pin_tie(pin_tie), .phase_in(phase_in),
      .gate_hi(gate_hi), .gate_lo(gate_lo));
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   task complete_run;
      begin
         $display("mismatches %0d compares %0d", fail_count, cmp_count);
         if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   // one single transfer; waits on hready in both phases
   task ahb(input w, input [31:0] a, input [31:0] d, output [31:0] r);
      begin
         @(posedge ref_clk);
         hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
         @(posedge ref_clk);
         while (hreadyout !== 1'b1) @(posedge ref_clk);
         hsel <= 0; htrans <= 2'h0; hwdata <= d;
         @(posedge ref_clk);
         while (hreadyout !== 1'b1) @(posedge ref_clk);
         r = hrdata;
      end
   endtask
   task wait_st(input [7:0] e);
      integer i;
      begin
         st = 0;
         for (i = 0; i < 3000 && st[7:0] !== e; i = i + 1) ahb(0, 32'h4, 0, st);
         chk(st[7:0], e);
      end
   endtask
   task gates(input [7:0] n);
      begin
         acc = 0;
         repeat (n) begin
            @(posedge ref_clk);
            acc = acc | gate_hi;
         end
      end
   endtask
   task run(input t, input f, input [3:0] tie, input [2:0] det);
      begin
         srst <= 1; tri_level_sel <= t; mode_fixed <= f; pin_tie <= tie; enable_ok <= 0; por_done <= 0;
         pll_locked <= 0; ss_done <= 0; output_in_window <= 0; load_lt_3ph <= 0; load_lt_2ph <= 0;
         light_load <= 0; deep_light_load <= 0; inductor_zero <= 0;
         repeat (4) @(posedge ref_clk);
         srst <= 0;
         ahb(0, 32'h0, 0, st);
         chk({st, hresp}, 33'h0_0064_00C8);
         ahb(1, 32'h0, 32'h0008_0030, st);
         ahb(0, 32'h0, 0, st);
         chk(st, 32'h0008_0030);
         ahb(0, 32'h8, 0, st);
         chk(st, 0);
         enable_ok <= 1;
         wait_st(8'h01);
         por_done <= 1;
         if (tie[1:0] != 0) begin
            wait_st(8'h80);
            chk(latched_off, 1);
         end else begin
            wait_st(8'h04);
            wait_st(8'h08);
            chk(st[14:12], det);
            acc = 0;
            repeat (20) @(posedge ref_clk) acc[0] = acc[0] | clk_out;
            chk(acc, 0);
            pll_locked <= 1;
            wait_st(8'h10);
            chk({prebias_en, gate_hi, gate_lo}, 9'h100);
            acc = 0;
            repeat (60) @(posedge ref_clk) acc = acc | {2'b00, clk_out, ~clk_out};
            chk(acc, 4'h3);
            wait_st(8'h20);
            gates(100);
            chk({drive_enable, acc[0]}, {1'b1, !t});
            ss_done <= 1;
            wait_st(8'h40);
            output_in_window <= 1;
            repeat (3) @(posedge ref_clk);
            chk(output_ok_flag, 1);
            gates(100);
            chk(acc[0], 1);
            load_lt_3ph <= 1; load_lt_2ph <= 1; light_load <= 1; deep_light_load <= 1; inductor_zero <= 3;
            repeat (8) @(posedge ref_clk);
            ahb(0, 32'h4, 0, st);
            chk(st[10:8], f ? det : 3'h2);
            chk(st[18:17], f ? 2'h0 : 2'h3);
            chk(phase_mid[1:0], (t && !f) ? 2'h3 : 2'h0);
         end
      end
   endtask
   initial begin
      #1000000;
      fail_count = fail_count + 1;
      $display("BAD %0t timeout", $time);
      complete_run;
   end
   initial begin
      srst = 1; hsel = 0; hwrite = 0; htrans = 0; haddr = 0; hwdata = 0; enable_ok = 0; por_done = 0;
      mode_fixed = 1; tri_level_sel = 0; pll_locked = 0; ss_done = 0; output_in_window = 0; pin_tie = 0;
      load_lt_3ph = 0; load_lt_2ph = 0; light_load = 0; deep_light_load = 0; inductor_zero = 0;
      fail_count = 0; cmp_count = 0; st = 0; acc = 0;
      @(posedge ref_clk);
      // mode_fixed, driven from f, selects fixed phases in the runs with f set
      run(1, 1, 4'h0, 3'h4);
      run(1, 0, 4'h8, 3'h3);
      run(0, 1, 4'h4, 3'h2);
      run(0, 0, 4'h0, 3'h4);
      run(0, 0, 4'h2, 3'h0);
      complete_run;
   end
endmodule
